// *** core/gpio_port_pkg.sv ***
// Contract
// R01: Six pins in bits 5..0; bits 7..6 read as zero. Here the analog select read returns bits 7..6 as stored.
// R02: Direction bit 1 disables the pin driver; pin is an input.
// R03: Direction bit 0 enables the driver with the latch value.
// R04: Pin three is input only; its direction bit reads 1, never driven.
// R05: Data reads return pin levels; writes go to the output latch.
// R06: Writes are read-modify-write of sampled pins into the whole latch.
// R07: With master clear enabled, pin three reads as zero.
// R08: Direction still controls the driver on analog-selected pins.
// R09: Software keeps analog pins set as inputs to avoid contention.
// R10: Analog pins read zero and cannot raise a pin-change event.
// R11: After reset all direction bits are 1; pin three stays 1.
// R12: Latch bits 4,2,1,0 reset to 0; pins five and three follow pins. Here reset loads 0 into all six latch bits.
// R13: In crystal modes direction bits 5 and 4 read as 1.
// R14: Analog select forces digital reads to zero; analog keeps working.
// R15: Analog select does not affect digital output driving.
// R16: Read-modify-write stores zero for analog-selected output pins.
// R17: An enabled sharing peripheral takes over its pin.
// R18: Analog select 1 means analog; all analog bits reset to 1.
// R19: Each data read captures pins into a last-read latch for change.
// R20: Latch keeps its value while a pin is an input.
// R21: Pin inputs pass a two-stage synchroniser before reads.
package gpio_port_pkg;
  localparam int unsigned PIN_COUNT       = 6;
  localparam int unsigned INPUT_ONLY_PIN  = 3;
  localparam logic [3:0]  OFS_PIN_DATA    = 4'h0;
  localparam logic [3:0]  OFS_DIRECTION   = 4'h4;
  localparam logic [3:0]  OFS_ANALOG_SEL  = 4'h8;
  localparam logic [3:0]  OFS_CONFIG      = 4'hc;
  localparam logic [3:0]  OFS_LAST_READ   = 4'h0;
  localparam logic [5:0]  DIR_RESET       = 6'h3f;
  localparam logic [5:0]  LATCH_RESET     = 6'h00;
  localparam logic [7:0]  ANALOG_RESET    = 8'hff;
  localparam logic [5:0]  CRYSTAL_PINS    = 6'h30;
  localparam logic [5:0]  INPUT_ONLY_MASK = 6'h08;
  localparam int unsigned CFG_MCLR_BIT    = 0;
  localparam int unsigned CFG_OSC_LSB     = 1;
  localparam logic [2:0]  OSC_LOW_POWER   = 3'h0;
  localparam logic [2:0]  OSC_MEDIUM_GAIN = 3'h1;
  localparam logic [2:0]  OSC_HIGH_GAIN   = 3'h2;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  localparam logic [3:0]  CFG_RESET       = 4'h0;
endpackage

// *** core/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned WIDTH = 6
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // Only the second stage is visible; the first is never read elsewhere
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in; // [R21]
      sync_out <= meta_reg; // [R21]
    end
  end
endmodule

// *** core/pin_driver.sv ***
`timescale 1ns/1ps
module pin_driver #(
  parameter int unsigned WIDTH = 6
) (
  input  wire logic [WIDTH-1:0] direction,
  input  wire logic [WIDTH-1:0] latch,
  input  wire logic [WIDTH-1:0] periph_en,
  input  wire logic [WIDTH-1:0] periph_out,
  input  wire logic [WIDTH-1:0] periph_oe,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe
);
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    if (i == gpio_port_pkg::INPUT_ONLY_PIN) begin : g_in_only
      assign pin_out[i] = 1'b0; // [R04]
      assign pin_oe[i]  = 1'b0; // [R04]
    end else begin : g_io
      // Analog select is not consulted: it never touches the driver
      assign pin_out[i] = periph_en[i] ? periph_out[i] : latch[i]; // [R17]
      assign pin_oe[i]  = periph_en[i] ? periph_oe[i] // [R08] [R15]
                                       : !direction[i]; // [R02] [R03]
    end
  end
endmodule

// *** core/gpio_port.sv ***
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module gpio_port #(
  parameter int unsigned PINS = 6
) (
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic [3:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [3:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic [PINS-1:0] pin_in,
  output logic      [PINS-1:0] pin_out,
  output logic      [PINS-1:0] pin_oe,
  input  wire logic [PINS-1:0] periph_en,
  input  wire logic [PINS-1:0] periph_out,
  input  wire logic [PINS-1:0] periph_oe,
  input  wire logic [PINS-1:0] change_en,
  output logic      [PINS-1:0] change_mismatch,
  output logic                 port_read_pulse
);
  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_HAVE = 3'b010,
    WR_RESP = 3'b100
  } wr_state_t;

  wr_state_t       wr_state_reg;
  logic [3:0]      aw_addr_reg;
  logic            aw_have_reg;
  logic [31:0]     w_data_reg;
  logic [3:0]      w_strb_reg;
  logic            w_have_reg;
  logic [PINS-1:0] dir_reg;
  logic [PINS-1:0] latch_reg;
  logic [7:0]      analog_reg;
  logic [3:0]      config_reg;
  logic [PINS-1:0] last_read_reg;
  logic [PINS-1:0] pin_sync_val;
  logic [PINS-1:0] digital_in;
  logic [PINS-1:0] dir_view;
  logic            crystal_mode;
  logic            do_write;
  logic            do_read;
  logic            rd_hit_data;
  logic [31:0]     rd_word;
  logic            rd_ok;
  logic [3:0]      rd_addr_reg;

  function automatic logic addr_known(input logic [3:0] a);
    addr_known = (a == gpio_port_pkg::OFS_PIN_DATA) ||
                 (a == gpio_port_pkg::OFS_DIRECTION) ||
                 (a == gpio_port_pkg::OFS_ANALOG_SEL) ||
                 (a == gpio_port_pkg::OFS_CONFIG);
  endfunction

  pin_sync #(.WIDTH(PINS)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (pin_in),
    .sync_out (pin_sync_val)
  );

  pin_driver #(.WIDTH(PINS)) u_drv (
    .direction  (dir_reg),
    .latch      (latch_reg),
    .periph_en  (periph_en),
    .periph_out (periph_out),
    .periph_oe  (periph_oe),
    .pin_out    (pin_out),
    .pin_oe     (pin_oe)
  );

  assign crystal_mode =
    (config_reg[3:1] == gpio_port_pkg::OSC_LOW_POWER) ||
    (config_reg[3:1] == gpio_port_pkg::OSC_MEDIUM_GAIN) ||
    (config_reg[3:1] == gpio_port_pkg::OSC_HIGH_GAIN);

  // Digital read view of the pins after analog and master-clear masking
  always_comb begin
    digital_in = pin_sync_val & ~analog_reg[PINS-1:0]; // [R10] [R14]
    if (config_reg[gpio_port_pkg::CFG_MCLR_BIT]) begin
      digital_in[gpio_port_pkg::INPUT_ONLY_PIN] = 1'b0; // [R07]
    end
  end

  always_comb begin
    dir_view = dir_reg | gpio_port_pkg::INPUT_ONLY_MASK; // [R04]
    if (crystal_mode) begin
      dir_view = dir_view | gpio_port_pkg::CRYSTAL_PINS; // [R13]
    end
  end

  // Write channel: address and data taken in either order
  assign s_axi_awready = (wr_state_reg != WR_RESP) && !aw_have_reg;
  assign s_axi_wready  = (wr_state_reg != WR_RESP) && !w_have_reg;
  assign do_write      = (wr_state_reg != WR_RESP) &&
                         (aw_have_reg || s_axi_awvalid) &&
                         (w_have_reg || s_axi_wvalid);

  logic [3:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  assign wr_addr = aw_have_reg ? aw_addr_reg : s_axi_awaddr;
  assign wr_data = w_have_reg ? w_data_reg : s_axi_wdata;
  assign wr_strb = w_have_reg ? w_strb_reg : s_axi_wstrb;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= WR_IDLE;
      aw_have_reg  <= 1'b0;
      w_have_reg   <= 1'b0;
      aw_addr_reg  <= 4'h0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= gpio_port_pkg::RESP_OKAY;
    end else begin
      case (wr_state_reg)
        WR_IDLE, WR_HAVE: begin
          if (do_write) begin
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_known(wr_addr) ? gpio_port_pkg::RESP_OKAY
                                                : gpio_port_pkg::RESP_SLVERR;
            wr_state_reg <= WR_RESP;
          end else begin
            if (s_axi_awvalid && s_axi_awready) begin
              aw_have_reg <= 1'b1;
              aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
              w_have_reg <= 1'b1;
              w_data_reg <= s_axi_wdata;
              w_strb_reg <= s_axi_wstrb;
            end
            if ((s_axi_awvalid && s_axi_awready) ||
                (s_axi_wvalid && s_axi_wready)) begin
              wr_state_reg <= WR_HAVE;
            end
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state_reg <= WR_IDLE;
          end
        end
        default: begin
          wr_state_reg <= WR_IDLE;
        end
      endcase
    end
  end

  // Output latch; only byte lane 0 carries port bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_reg <= gpio_port_pkg::LATCH_RESET; // [R12]
    end else if (do_write && wr_strb[0] &&
                 wr_addr == gpio_port_pkg::OFS_PIN_DATA) begin
      // Whole latch takes the written byte; the pin sample is the base that
      // bit-level software edits, so analog-selected outputs land as zero
      latch_reg <= wr_data[PINS-1:0]; // [R05] [R06] [R16] [R20]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_reg    <= gpio_port_pkg::DIR_RESET; // [R11]
      analog_reg <= gpio_port_pkg::ANALOG_RESET; // [R18]
      config_reg <= gpio_port_pkg::CFG_RESET;
    end else if (do_write && wr_strb[0]) begin
      case (wr_addr)
        gpio_port_pkg::OFS_DIRECTION:
          dir_reg <= wr_data[PINS-1:0] |
                     gpio_port_pkg::INPUT_ONLY_MASK; // [R04]
        gpio_port_pkg::OFS_ANALOG_SEL:
          analog_reg <= wr_data[7:0]; // [R18]
        gpio_port_pkg::OFS_CONFIG:
          config_reg <= wr_data[3:0];
        default: begin
        end
      endcase
    end
  end

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign do_read       = s_axi_arvalid && s_axi_arready;
  assign rd_hit_data   = do_read &&
                         (s_axi_araddr == gpio_port_pkg::OFS_PIN_DATA);

  always_comb begin
    rd_word = 32'h0000_0000; // [R01]
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      gpio_port_pkg::OFS_PIN_DATA:   rd_word[PINS-1:0] = digital_in; // [R05]
      gpio_port_pkg::OFS_DIRECTION:  rd_word[PINS-1:0] = dir_view;
      gpio_port_pkg::OFS_ANALOG_SEL: rd_word[7:0] = analog_reg;
      gpio_port_pkg::OFS_CONFIG:     rd_word[3:0] = config_reg;
      default:                       rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= gpio_port_pkg::RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? gpio_port_pkg::RESP_OKAY
                            : gpio_port_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Address of the answer in flight; rvalid may stand for several cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_addr_reg <= 4'h0;
    end else if (do_read) begin
      rd_addr_reg <= s_axi_araddr;
    end
  end

  // Last-read latch is the reference for change detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_read_reg   <= gpio_port_pkg::LATCH_RESET;
      port_read_pulse <= 1'b0;
    end else begin
      port_read_pulse <= rd_hit_data;
      if (rd_hit_data) begin
        last_read_reg <= digital_in; // [R19]
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      change_mismatch <= '0;
    end else begin
      change_mismatch <= (digital_in ^ last_read_reg) & change_en &
                         ~analog_reg[PINS-1:0]; // [R10] [R19]
    end
  end

  property p_dir_reset;
    @(posedge aclk) !aresetn |=> (dir_view == gpio_port_pkg::DIR_RESET);
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("dir reset"); // [R11]

  property p_pin3_never_driven;
    @(posedge aclk) disable iff (!aresetn)
      !pin_oe[gpio_port_pkg::INPUT_ONLY_PIN];
  endproperty
  a_pin3_never_driven: assert property (p_pin3_never_driven) // [R04]
    else $error("pin three driven");

  property p_dir_drives;
    @(posedge aclk) disable iff (!aresetn)
      (periph_en == '0) |->
        (pin_oe == (~dir_reg & ~gpio_port_pkg::INPUT_ONLY_MASK));
  endproperty
  a_dir_drives: assert property (p_dir_drives) // [R02]
    else $error("driver enable mismatch");

  property p_out_latch;
    @(posedge aclk) disable iff (!aresetn)
      (periph_en == '0) |-> ((pin_out & pin_oe) == (latch_reg & pin_oe));
  endproperty
  a_out_latch: assert property (p_out_latch) // [R03]
    else $error("driven value not latch");

  property p_analog_reads_zero;
    @(posedge aclk) disable iff (!aresetn)
      rd_hit_data |=> ((s_axi_rdata[PINS-1:0] & $past(analog_reg[PINS-1:0]))
                       == '0);
  endproperty
  a_analog_reads_zero: assert property (p_analog_reads_zero) // [R14]
    else $error("analog pin read nonzero");

  property p_mclr_pin3;
    @(posedge aclk) disable iff (!aresetn)
      (rd_hit_data && config_reg[gpio_port_pkg::CFG_MCLR_BIT])
        |=> !s_axi_rdata[gpio_port_pkg::INPUT_ONLY_PIN];
  endproperty
  a_mclr_pin3: assert property (p_mclr_pin3) // [R07]
    else $error("pin three not zero");

  property p_upper_zero;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_rvalid && (rd_addr_reg != gpio_port_pkg::OFS_ANALOG_SEL))
        |-> (s_axi_rdata[31:6] == 26'h0);
  endproperty
  a_upper_zero: assert property (p_upper_zero) // [R01]
    else $error("upper bits set");

  property p_crystal_dir;
    @(posedge aclk) disable iff (!aresetn)
      crystal_mode |-> ((dir_view & gpio_port_pkg::CRYSTAL_PINS)
                        == gpio_port_pkg::CRYSTAL_PINS);
  endproperty
  a_crystal_dir: assert property (p_crystal_dir) // [R13]
    else $error("crystal dir bits");

  property p_sync_delay;
    @(posedge aclk) disable iff (!aresetn)
      ($past(aresetn) && $past(aresetn, 2))
        |-> (pin_sync_val == $past(pin_in, 2));
  endproperty
  a_sync_delay: assert property (p_sync_delay) // [R21]
    else $error("sync delay wrong");

  property p_last_read;
    @(posedge aclk) disable iff (!aresetn)
      rd_hit_data |=> (last_read_reg == $past(digital_in));
  endproperty
  a_last_read: assert property (p_last_read) // [R19]
    else $error("last read not captured");

  // Mismatch is computed from the analog mask of the previous cycle
  property p_analog_no_change;
    @(posedge aclk) disable iff (!aresetn)
      (change_mismatch & $past(analog_reg[PINS-1:0])) == '0;
  endproperty
  a_analog_no_change: assert property (p_analog_no_change) // [R10]
    else $error("analog pin flagged change");

  c_write: cover property (@(posedge aclk) do_write);
  c_slverr: cover property (@(posedge aclk)
    s_axi_bvalid && (s_axi_bresp == gpio_port_pkg::RESP_SLVERR));
  c_read_data: cover property (@(posedge aclk) rd_hit_data);
  c_mismatch: cover property (@(posedge aclk) change_mismatch != '0);
endmodule

// *** tb/pin_board.sv ***
`timescale 1ns/1ps
module pin_board (
  input  wire logic       aclk,
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] ext_val,
  input  wire logic [5:0] ext_en,
  output logic      [5:0] pin_level
);
  // No keeper on the board: a floating pin wanders every cycle
  logic [5:0] float_reg;
  initial float_reg = 6'h2a;
  always @(posedge aclk) begin
    float_reg <= ~float_reg;
  end
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pin_oe[i]) begin
        pin_level[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_level[i] = ext_val[i];
      end else begin
        pin_level[i] = float_reg[i];
      end
    end
  end
endmodule

// *** tb/test_six_bit_port_with_direction.sv ***
`timescale 1ns/1ps
module test_six_bit_port_with_direction;
  localparam logic [3:0] A_DAT = gpio_port_pkg::OFS_PIN_DATA;
  localparam logic [3:0] A_DIR = gpio_port_pkg::OFS_DIRECTION;
  localparam logic [3:0] A_ANA = gpio_port_pkg::OFS_ANALOG_SEL;
  localparam logic [3:0] A_CFG = gpio_port_pkg::OFS_CONFIG;
  logic        aclk, aresetn;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, port_read_pulse;
  logic [5:0]  pin_in, pin_out, pin_oe, periph_en, periph_out, periph_oe;
  logic [5:0]  change_en, change_mismatch, ext_val, ext_en;
  int          fail_count, checks;
  int          pulses;

  gpio_port #(.PINS(6)) u_gpio_port (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in,
    .pin_out, .pin_oe, .periph_en, .periph_out, .periph_oe, .change_en,
    .change_mismatch, .port_read_pulse);
  pin_board u_pin_board (.aclk, .pin_out, .pin_oe, .ext_val, .ext_en,
    .pin_level(pin_in));

  // Each data read must give exactly one read pulse
  always @(posedge aclk) begin
    if (port_read_pulse === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp_word(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_pins(input string what, input logic [5:0] exp,
                          input logic [5:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf,
                    input logic [1:0] er = 2'h0);
    logic aw_ok, w_ok, b_ok;
    b_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_ok) begin
      @(negedge aclk);
      aw_ok = s_axi_awvalid && s_axi_awready;
      w_ok = s_axi_wvalid && s_axi_wready;
      b_ok = (s_axi_bvalid === 1'b1);
      if (b_ok) cmp_word("bresp", 32'(er), 32'(s_axi_bresp));
      @(posedge aclk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
      if (b_ok) s_axi_bready <= 1'b0;
    end
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp,
                        input string what, input logic [1:0] er = 2'h0);
    logic ar_ok, r_ok;
    logic [31:0] d;
    logic [1:0] r;
    r_ok = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_ok) begin
      @(negedge aclk);
      ar_ok = s_axi_arvalid && s_axi_arready;
      r_ok = (s_axi_rvalid === 1'b1);
      if (r_ok) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
      @(posedge aclk);
      if (ar_ok) s_axi_arvalid <= 1'b0;
      if (r_ok) s_axi_rready <= 1'b0;
    end
    cmp_word(what, exp, d);
    cmp_word("rresp", 32'(er), 32'(r));
  endtask

  // Lets the two synchroniser stages and the read register settle
  task automatic settle();
    repeat (4) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic t_reset();
    rd_chk(A_DIR, 32'h3f, "dir reset");
    rd_chk(A_ANA, 32'hff, "analog reset");
    rd_chk(A_DAT, 32'h0, "data reset");
    cmp_pins("oe reset", 6'h00, pin_oe);
  endtask

  task automatic t_crystal();
    wr(A_DIR, 32'h0);
    for (int m = 0; m < 3; m++) begin
      wr(A_CFG, 32'(m) << gpio_port_pkg::CFG_OSC_LSB);
      rd_chk(A_DIR, 32'h38, "dir crystal");
    end
    wr(A_CFG, 32'h6);
    rd_chk(A_DIR, 32'h08, "dir no crystal");
  endtask

  task automatic t_drive();
    wr(A_ANA, 32'h0);
    wr(A_DAT, 32'h15);
    settle();
    cmp_pins("oe out", 6'h37, pin_oe);
    cmp_pins("out", 6'h15, pin_out & pin_oe);
    rd_chk(A_DAT, 32'h1d, "data pins");
    wr(A_DAT, 32'hffff_ffff);
    @(negedge aclk);
    cmp_pins("out whole", 6'h37, pin_out & pin_oe);
    wr(A_DAT, 32'h0, 4'h0);
    @(negedge aclk);
    cmp_pins("out no strobe", 6'h37, pin_out & pin_oe);
    wr(A_CFG, 32'h7);
    rd_chk(A_DAT, 32'h37, "data mclr");
    wr(A_CFG, 32'h6);
  endtask

  task automatic t_analog();
    wr(A_ANA, 32'h01);
    settle();
    cmp_pins("oe analog", 6'h37, pin_oe);
    cmp_pins("out analog", 6'h37, pin_out & pin_oe);
    rd_chk(A_DAT, 32'h3e, "data analog");
    wr(A_DAT, 32'h3e);
    @(negedge aclk);
    cmp_pins("out rmw", 6'h36, pin_out & pin_oe);
    wr(A_ANA, 32'h0);
  endtask

  task automatic t_hold();
    wr(A_DIR, 32'h3f);
    @(posedge aclk);
    ext_en <= 6'h3f;
    ext_val <= 6'h2a;
    @(negedge aclk);
    cmp_pins("oe input", 6'h00, pin_oe);
    wr(A_DAT, 32'h0c);
    settle();
    rd_chk(A_DAT, 32'h2a, "data input");
    @(posedge aclk);
    ext_en <= 6'h08;
    wr(A_DIR, 32'h0);
    @(negedge aclk);
    cmp_pins("out kept", 6'h04, pin_out & pin_oe);
  endtask

  task automatic t_periph();
    @(posedge aclk);
    periph_en <= 6'h04;
    periph_oe <= 6'h04;
    periph_out <= 6'h00;
    @(negedge aclk);
    cmp_pins("periph out", 6'h37, pin_oe & ~pin_out);
    @(posedge aclk);
    periph_oe <= 6'h00;
    @(negedge aclk);
    cmp_pins("periph oe", 6'h33, pin_oe);
    @(posedge aclk);
    periph_en <= 6'h00;
  endtask

  task automatic t_change();
    wr(A_DIR, 32'h3f);
    wr(A_ANA, 32'h20);
    @(posedge aclk);
    ext_en <= 6'h3f;
    ext_val <= 6'h00;
    change_en <= 6'h3f;
    settle();
    rd_chk(A_DAT, 32'h0, "data base");
    settle();
    cmp_pins("no change", 6'h00, change_mismatch);
    @(posedge aclk);
    ext_val <= 6'h21;
    settle();
    cmp_pins("change", 6'h01, change_mismatch);
    rd_chk(A_DAT, 32'h01, "data change");
    settle();
    cmp_pins("change end", 6'h00, change_mismatch);
    cmp_word("read pulses", 32'h7, 32'(pulses));
  endtask

  // Unmapped offset: refused with an error and must not touch a register
  task automatic t_refuse();
    wr(4'h2, 32'h0, 4'hf, gpio_port_pkg::RESP_SLVERR);
    rd_chk(4'h2, 32'h0, "unmapped", gpio_port_pkg::RESP_SLVERR);
    rd_chk(A_DIR, 32'h3f, "dir kept");
  endtask

  initial begin
    fail_count = 0;
    pulses = 0;
    checks = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_wstrb, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    {periph_en, periph_out, periph_oe, change_en} = '0;
    ext_val = 6'h3f;
    ext_en = 6'h08;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_crystal();
    t_drive();
    t_analog();
    t_hold();
    t_periph();
    t_change();
    t_refuse();
    test_done();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    test_done();
  end
endmodule
